// ### inc/vuf_defines.svh
`ifndef VUF_DEFINES_SVH
`define VUF_DEFINES_SVH

// ----------------------------------------
// Command codes of the configuration registers
// ----------------------------------------
`define VUF_CMD_VIN_UV_LIMIT   8'h59
`define VUF_CMD_VIN_UV_ACTION  8'h5A
`define VUF_CMD_PG_ON          8'h5E
`define VUF_CMD_TURN_ON_DELAY_TIME      8'h60

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VUF_RST_ACTION         8'h80
`define VUF_RST_TURN_ON_DELAY_TIME      16'hCA80

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VUF_L11_EXP_MSB        15
`define VUF_L11_EXP_LSB        11
`define VUF_L11_MAN_MSB        10
`define VUF_L11_MAN_LSB        0
`define VUF_ACT_MODE_MSB       7
`define VUF_ACT_MODE_LSB       6
`define VUF_ACT_RETRY_MSB      5
`define VUF_ACT_RETRY_LSB      3

// ----------------------------------------
// Field codes
// ----------------------------------------
`define VUF_MODE_RETRY         2'h2
`define VUF_MODE_RESUME        2'h3
`define VUF_RETRY_NONE         3'h0
`define VUF_RETRY_FOREVER      3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define VUF_CLK_HZ             100000000
`define VUF_MS_PER_S           1000
`define VUF_MS_CYC             (`VUF_CLK_HZ / `VUF_MS_PER_S)
`define VUF_RETRY_UNIT_MS      70
`define VUF_TON_MIN_MS         3
`define VUF_TON_MAX_MS         5000
`define VUF_RISE_MIN_MS        1
`define VUF_RISE_MAX_MS        100
`define VUF_FRAC               8

`endif

// ### inc/vuf_pkg.sv
`include "vuf_defines.svh"

package vuf_pkg;

   typedef logic [12:0]        vuf_ms_t;
   typedef logic signed [47:0] vuf_fix_t;

   typedef enum logic [2:0] {
      VUF_OFF     = 3'b000,
      VUF_DELAY   = 3'b001,
      VUF_RISE    = 3'b010,
      VUF_ON      = 3'b011,
      VUF_RETRY   = 3'b100,
      VUF_LATCHED = 3'b101,
      VUF_HOLD    = 3'b110
   } vuf_state_t;

   // ----------------------------------------
   // Linear-11 word to signed fixed point with VUF_FRAC fraction bits
   // ----------------------------------------
   function automatic vuf_fix_t vuf_l11_fix(input logic [15:0] code);
      logic signed [5:0] e;
      logic [5:0]        ne;
      vuf_fix_t          m;
      e  = $signed({code[`VUF_L11_EXP_MSB], code[`VUF_L11_EXP_MSB:`VUF_L11_EXP_LSB]});
      ne = 6'(-e);
      m  = {{37{code[`VUF_L11_MAN_MSB]}}, code[`VUF_L11_MAN_MSB:`VUF_L11_MAN_LSB]};
      m  = m <<< `VUF_FRAC;
      if (e < 0) begin
         vuf_l11_fix = m >>> ne;
      end else begin
         vuf_l11_fix = m <<< e;
      end
   endfunction

   // Whole milliseconds of a Linear-11 time, fraction dropped, held in [lo, hi]
   function automatic vuf_ms_t vuf_ms_clamp(input logic [15:0] code,
                                            input vuf_ms_t     lo,
                                            input vuf_ms_t     hi);
      vuf_fix_t ms;
      ms = vuf_l11_fix(code) >>> `VUF_FRAC;
      if (ms < $signed({35'h0, lo})) begin
         vuf_ms_clamp = lo;
      end else if (ms > $signed({35'h0, hi})) begin
         vuf_ms_clamp = hi;
      end else begin
         vuf_ms_clamp = ms[12:0];
      end
   endfunction

endpackage

// ### rtl/vuf_ms_tick.sv
`include "vuf_defines.svh"

module vuf_ms_tick #(
   parameter int unsigned CYC = `VUF_MS_CYC
) (
   input  wire logic sys_clk,
   input  wire logic arst_n,
   input  wire logic clk_en,
   input  wire logic restart,
   output logic      tick
);

   logic [31:0] cnt;

   // Restart realigns the tick so a timed wait is whole milliseconds from its start
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt  <= 32'h0;
         tick <= 1'b0;
      end else if (clk_en) begin
         if (restart) begin
            cnt  <= 32'h0;
            tick <= 1'b0;
         end else if (cnt == 32'(CYC - 1)) begin
            cnt  <= 32'h0;
            tick <= 1'b1;
         end else begin
            cnt  <= cnt + 32'h1;
            tick <= 1'b0;
         end
      end
   end

endmodule

// ### rtl/vuf_ms_timer.sv
module vuf_ms_timer (
   input  wire logic            sys_clk,
   input  wire logic            arst_n,
   input  wire logic            clk_en,
   input  wire logic            load,
   input  wire vuf_pkg::vuf_ms_t load_ms,
   input  wire logic            tick,
   output logic                 done,
   output logic                 busy
);

   vuf_pkg::vuf_ms_t remain;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         remain <= 13'h0;
         busy   <= 1'b0;
         done   <= 1'b0;
      end else if (clk_en) begin
         if (load) begin
            remain <= load_ms;
            busy   <= 1'b1;
            done   <= 1'b0;
         end else if (busy && remain == 13'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
         end else begin
            done <= 1'b0;
            if (busy && tick) begin
               remain <= remain - 13'h1;
            end
         end
      end
   end

endmodule

// ### rtl/vuf_seq.sv
// How it works
// - UV limit: one global Linear-11 word, strap default
// - Action register resets to 80h, latched off
// - Retry interval counted in 70ms units
// - Fault sets sticky flag, alert low until clear
// - Mode 10: disable, then retry only if bits 5:3 are 111, else latch off
// - Mode 11: off while fault, auto resume after
// - Retry 000: stay off until fault cleared
// - Retry 111: restart forever until off/bias/fault
// - Power-good rises above Linear-16 on threshold
// - Power-good drops below output UV limit
// - Wait turn-on delay before output rise
// - Turn-on delay 0 to 5 s, ms Linear-11
// - Turn-on delay below 3ms acts as 3ms
// - Turn-on delay resets to CA80h, 5ms
// - Ramp over rise time, at least 1ms
`include "vuf_defines.svh"

module vuf_seq #(
   parameter int unsigned MS_CYCLES = `VUF_MS_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_cmd,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        clear_faults,
   input  wire logic [15:0] strap_vin_uv_limit,
   input  wire logic [15:0] strap_pg_on,
   input  wire logic [15:0] ton_rise_code,
   input  wire logic [15:0] vin_meas,
   input  wire logic [15:0] vout_meas,
   input  wire logic [15:0] vout_uv_limit,
   input  wire logic        run_req,
   input  wire logic        bias_ok,
   input  wire logic        other_fault,
   output logic [15:0]      reg_rdata,
   output logic             reg_rd_valid,
   output logic             alert_output_line_n,
   output logic             vin_uv_fault_flag,
   output logic             output_enabled,
   output logic             ramp_active,
   output logic             power_good,
   output logic [2:0]       seq_state
);

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [15:0] input_undervoltage_fault_threshold;
   logic [7:0]  input_undervoltage_fault_action;
   logic [15:0] power_good_assert_threshold;
   logic [15:0] turn_on_delay_time;
   logic        strap_taken;

   wire logic wr_uv_limit = reg_wr && reg_cmd == `VUF_CMD_VIN_UV_LIMIT;
   wire logic wr_action   = reg_wr && reg_cmd == `VUF_CMD_VIN_UV_ACTION;
   wire logic wr_pg_on    = reg_wr && reg_cmd == `VUF_CMD_PG_ON;
   wire logic wr_ton      = reg_wr && reg_cmd == `VUF_CMD_TURN_ON_DELAY_TIME;

   // Strap defaults are captured on the first enabled edge after reset release,
   // since an asynchronous reset may only load constants.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_taken <= 1'b0;
      end else if (clk_en) begin
         strap_taken <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         input_undervoltage_fault_threshold <= 16'h0000;
      end else if (clk_en) begin
         if (!strap_taken) begin
            input_undervoltage_fault_threshold <= strap_vin_uv_limit;
         end else if (wr_uv_limit) begin
            input_undervoltage_fault_threshold <= reg_wdata;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         power_good_assert_threshold <= 16'h0000;
      end else if (clk_en) begin
         if (!strap_taken) begin
            power_good_assert_threshold <= strap_pg_on;
         end else if (wr_pg_on) begin
            power_good_assert_threshold <= reg_wdata;
         end
      end
   end

   // All eight bits are stored and read back; bits 2:0 steer nothing
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         input_undervoltage_fault_action <= `VUF_RST_ACTION;
      end else if (clk_en && wr_action) begin
         input_undervoltage_fault_action <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         turn_on_delay_time <= `VUF_RST_TURN_ON_DELAY_TIME;
      end else if (clk_en && wr_ton) begin
         turn_on_delay_time <= reg_wdata;
      end
   end

   // ----------------------------------------
   // Read-back
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata    <= 16'h0000;
         reg_rd_valid <= 1'b0;
      end else if (clk_en) begin
         reg_rd_valid <= reg_rd;
         if (reg_rd) begin
            if (reg_cmd == `VUF_CMD_VIN_UV_LIMIT) begin
               reg_rdata <= input_undervoltage_fault_threshold;
            end else if (reg_cmd == `VUF_CMD_VIN_UV_ACTION) begin
               reg_rdata <= {8'h00, input_undervoltage_fault_action};
            end else if (reg_cmd == `VUF_CMD_PG_ON) begin
               reg_rdata <= power_good_assert_threshold;
            end else if (reg_cmd == `VUF_CMD_TURN_ON_DELAY_TIME) begin
               reg_rdata <= turn_on_delay_time;
            end else begin
               reg_rdata <= 16'h0000;
            end
         end
      end
   end

   // ----------------------------------------
   // Decoded settings
   // ----------------------------------------
   wire logic [1:0] act_mode =
      input_undervoltage_fault_action[`VUF_ACT_MODE_MSB:`VUF_ACT_MODE_LSB];
   wire logic [2:0] act_retry =
      input_undervoltage_fault_action[`VUF_ACT_RETRY_MSB:`VUF_ACT_RETRY_LSB];

   // Both words go through the same decoder so exponents need not match
   wire logic vin_low =
      vuf_pkg::vuf_l11_fix(vin_meas) <
      vuf_pkg::vuf_l11_fix(input_undervoltage_fault_threshold);

   // Fractions of a millisecond are dropped before clamping
   wire vuf_pkg::vuf_ms_t ton_ms =
      vuf_pkg::vuf_ms_clamp(turn_on_delay_time,
                            13'(`VUF_TON_MIN_MS), 13'(`VUF_TON_MAX_MS));
   wire vuf_pkg::vuf_ms_t rise_ms =
      vuf_pkg::vuf_ms_clamp(ton_rise_code,
                            13'(`VUF_RISE_MIN_MS), 13'(`VUF_RISE_MAX_MS));

   // ----------------------------------------
   // Timebase
   // ----------------------------------------
   logic             tmr_load;
   vuf_pkg::vuf_ms_t tmr_ms;
   logic             ms_tick;
   logic             tmr_done;

   vuf_ms_tick #(
      .CYC (MS_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .restart (tmr_load),
      .tick    (ms_tick)
   );

   vuf_ms_timer u_timer (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .clk_en  (clk_en),
      .load    (tmr_load),
      .load_ms (tmr_ms),
      .tick    (ms_tick),
      .done    (tmr_done),
      .busy    ()
   );

   // ----------------------------------------
   // Start-up and fault sequencer
   // ----------------------------------------
   vuf_pkg::vuf_state_t state;
   vuf_pkg::vuf_state_t next_state;
   logic                uv_event;
   logic                stop_all;

   wire logic live = state == vuf_pkg::VUF_DELAY || state == vuf_pkg::VUF_RISE ||
                     state == vuf_pkg::VUF_ON;

   always_comb begin
      // Off command, loss of bias or another shutdown fault overrides every retry
      stop_all   = !run_req || !bias_ok || other_fault;
      uv_event   = live && vin_low;
      next_state = state;
      tmr_load   = 1'b0;
      tmr_ms     = ton_ms;
      if (stop_all) begin
         next_state = vuf_pkg::VUF_OFF;
      end else begin
         case (state)
            vuf_pkg::VUF_OFF: begin
               // A first start is refused while the input is already low
               if (!vin_low) begin
                  next_state = vuf_pkg::VUF_DELAY;
                  tmr_load   = 1'b1;
                  tmr_ms     = ton_ms;
               end
            end
            vuf_pkg::VUF_DELAY, vuf_pkg::VUF_RISE, vuf_pkg::VUF_ON: begin
               if (uv_event) begin
                  if (act_mode == `VUF_MODE_RESUME) begin
                     next_state = vuf_pkg::VUF_HOLD;
                  end else if (act_mode == `VUF_MODE_RETRY &&
                               act_retry == `VUF_RETRY_FOREVER) begin
                     next_state = vuf_pkg::VUF_RETRY;
                     tmr_load   = 1'b1;
                     tmr_ms     = 13'(`VUF_RETRY_UNIT_MS);
                  end else begin
                     // Unused codes fall back to the safe latched shutdown
                     next_state = vuf_pkg::VUF_LATCHED;
                  end
               end else if (state == vuf_pkg::VUF_DELAY && tmr_done) begin
                  next_state = vuf_pkg::VUF_RISE;
                  tmr_load   = 1'b1;
                  tmr_ms     = rise_ms;
               end else if (state == vuf_pkg::VUF_RISE && tmr_done) begin
                  next_state = vuf_pkg::VUF_ON;
               end
            end
            vuf_pkg::VUF_RETRY: begin
               // Restart without looking at the input; a low input trips again
               if (tmr_done) begin
                  next_state = vuf_pkg::VUF_DELAY;
                  tmr_load   = 1'b1;
                  tmr_ms     = ton_ms;
               end
            end
            vuf_pkg::VUF_HOLD: begin
               if (!vin_low) begin
                  next_state = vuf_pkg::VUF_DELAY;
                  tmr_load   = 1'b1;
                  tmr_ms     = ton_ms;
               end
            end
            vuf_pkg::VUF_LATCHED: begin
               if (clear_faults) begin
                  next_state = vuf_pkg::VUF_OFF;
               end
            end
            default: begin
               next_state = vuf_pkg::VUF_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= vuf_pkg::VUF_OFF;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // Output drive, registered from the next state
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         output_enabled <= 1'b0;
         ramp_active    <= 1'b0;
         seq_state      <= 3'h0;
      end else if (clk_en) begin
         output_enabled <= next_state == vuf_pkg::VUF_DELAY ||
                           next_state == vuf_pkg::VUF_RISE ||
                           next_state == vuf_pkg::VUF_ON;
         ramp_active    <= next_state == vuf_pkg::VUF_RISE;
         seq_state      <= next_state;
      end
   end

   // ----------------------------------------
   // Sticky fault flag and alert
   // ----------------------------------------
   // A fault in the same cycle as the clear command keeps the flag set
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         vin_uv_fault_flag   <= 1'b0;
         alert_output_line_n <= 1'b1;
      end else if (clk_en) begin
         if (uv_event) begin
            vin_uv_fault_flag   <= 1'b1;
            alert_output_line_n <= 1'b0;
         end else if (clear_faults) begin
            vin_uv_fault_flag   <= 1'b0;
            alert_output_line_n <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Power-good with hysteresis
   // ----------------------------------------
   // Relies on the on threshold sitting above the UV limit; otherwise the
   // clear below wins and power-good switches at the UV limit with no hysteresis.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         power_good <= 1'b0;
      end else if (clk_en) begin
         if (!(next_state == vuf_pkg::VUF_RISE || next_state == vuf_pkg::VUF_ON)) begin
            power_good <= 1'b0;
         end else if (vout_meas < vout_uv_limit) begin
            power_good <= 1'b0;
         end else if (vout_meas > power_good_assert_threshold) begin
            power_good <= 1'b1;
         end
      end
   end

endmodule

// ### verification/vuf_seq_chk.sv
module vuf_seq_chk #(
   parameter int unsigned MS_CYCLES = 10
) (
   input wire logic        sys_clk,
   input wire logic        arst_n,
   input wire logic        clk_en,
   input wire logic        clear_faults,
   input wire logic        run_req,
   input wire logic        bias_ok,
   input wire logic        other_fault,
   input wire logic [15:0] vout_meas,
   input wire logic [15:0] vout_uv_limit,
   input wire logic        alert_output_line_n,
   input wire logic        vin_uv_fault_flag,
   input wire logic        output_enabled,
   input wire logic        ramp_active,
   input wire logic        power_good,
   input wire logic [2:0]  seq_state
);
   timeunit 1ns;
   timeprecision 100ps;

   int unsigned dly_cnt;
   int unsigned ret_cnt;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------
   // Cycles spent in DELAY and in RETRY
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         dly_cnt <= 0;
      end else begin
         dly_cnt <= (seq_state == 3'h1) ? dly_cnt + 1 : 0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ret_cnt <= 0;
      end else begin
         ret_cnt <= (seq_state == 3'h4) ? ret_cnt + 1 : 0;
      end
   end

   sequence s_fault_entry;
      $rose(vin_uv_fault_flag) ##0 $past(output_enabled);
   endsequence

   sequence s_ramp_hold;
      ramp_active [*8];
   endsequence

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   alert_flag_a: assert property (alert_output_line_n != vin_uv_fault_flag)
      else $error("alert line disagrees with fault flag");
   flag_sticky_a: assert property (vin_uv_fault_flag && !clear_faults |=> vin_uv_fault_flag)
      else $error("fault flag dropped without clear");
   fault_live_a: assert property ($rose(vin_uv_fault_flag) |-> s_fault_entry)
      else $error("fault flagged while output not live");
   fault_off_a: assert property (s_fault_entry |-> !output_enabled)
      else $error("output still enabled after fault");
   ramp_len_a: assert property ($rose(ramp_active) |-> s_ramp_hold)
      else $error("ramp shorter than minimum rise");
   delay_min_a: assert property ($rose(ramp_active) |->
      dly_cnt >= 3 * MS_CYCLES && dly_cnt <= 5000 * MS_CYCLES + 4)
      else $error("turn-on delay outside 3 ms to 5 s");
   pg_live_a: assert property (power_good |-> seq_state inside {3'h2, 3'h3})
      else $error("power good outside rise or on");
   pg_drop_a: assert property (power_good && vout_meas < vout_uv_limit |=> !power_good)
      else $error("power good kept below output limit");
   retry_time_a: assert property (seq_state == 3'h1 && $past(seq_state) == 3'h4 |->
      ret_cnt >= 70 * MS_CYCLES - 2 && ret_cnt <= 70 * MS_CYCLES + 4)
      else $error("retry interval not 70 ms");
   latched_stay_a: assert property (clk_en && seq_state == 3'h5 && !clear_faults && run_req
      && bias_ok && !other_fault |=> seq_state == 3'h5)
      else $error("latched shutdown left without clear");
   stop_off_a: assert property (clk_en && (!run_req || !bias_ok || other_fault)
      |=> !output_enabled)
      else $error("output enabled after stop");
endmodule

// ### verification/vuf_host_model.sv
module vuf_host_model (
   input wire logic        sys_clk,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_rd_valid,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_cmd,
   output logic [15:0]     reg_wdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_cmd   = 8'h00;
      reg_wdata = 16'h0000;
   end

   // ----------------------------------------
   // One-cycle command pulses, driven off the sampling edge
   // ----------------------------------------
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge sys_clk);
      reg_wr    = 1'b1;
      reg_cmd   = c;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask

   // Missing answer returns unknown so the caller's compare fails
   task automatic rd(input logic [7:0] c, output logic [15:0] d);
      int i;
      @(negedge sys_clk);
      reg_rd  = 1'b1;
      reg_cmd = c;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      i = 0;
      while (reg_rd_valid !== 1'b1 && i < 4) begin
         @(negedge sys_clk);
         i++;
      end
      d = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hXXXX;
   endtask
endmodule

// ### verification/vuf_seq_bench.sv
`include "vuf_defines.svh"

`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("ERROR %0t %s", $time, m); end end

module vuf_seq_bench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned MS = 10;
   localparam logic [15:0] V_OK = 16'h0020;
   localparam logic [15:0] V_LOW = 16'hF81E;

   logic        sys_clk;
   logic        arst_n;
   logic        clk_en;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_cmd;
   logic [15:0] reg_wdata;
   logic        clear_faults;
   logic [15:0] vin_meas;
   logic [15:0] vout_meas;
   logic        run_req;
   logic        bias_ok;
   logic        other_fault;
   logic [15:0] reg_rdata;
   logic        reg_rd_valid;
   logic        alert_output_line_n;
   logic        vin_uv_fault_flag;
   logic        output_enabled;
   logic        ramp_active;
   logic        power_good;
   logic [2:0]  seq_state;
   logic [15:0] rdat;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          cyc = 0;

   vuf_seq #(.MS_CYCLES(MS)) dut (.sys_clk, .arst_n, .clk_en, .reg_wr, .reg_rd, .reg_cmd,
      .reg_wdata, .clear_faults, .strap_vin_uv_limit(16'h0010), .strap_pg_on(16'h0100),
      .ton_rise_code(16'h0001), .vin_meas, .vout_meas, .vout_uv_limit(16'h0080), .run_req,
      .bias_ok, .other_fault, .reg_rdata, .reg_rd_valid, .alert_output_line_n,
      .vin_uv_fault_flag, .output_enabled, .ramp_active, .power_good, .seq_state);

   vuf_host_model host (.sys_clk, .reg_rdata, .reg_rd_valid, .reg_wr, .reg_rd, .reg_cmd,
      .reg_wdata);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wait_st(input logic [2:0] s, input int lim);
      int i;
      i = 0;
      while (seq_state !== s && i < lim) begin
         @(negedge sys_clk);
         i++;
      end
   endtask

   task automatic start_on(input logic [7:0] act);
      host.wr(`VUF_CMD_VIN_UV_ACTION, {8'h00, act});
      vin_meas = V_OK;
      run_req  = 1'b1;
      wait_st(3'h3, 200);
      `CHK(seq_state, 3'h3, "not on")
      vin_meas = V_LOW;
      repeat (2) @(negedge sys_clk);
   endtask

   // Clearing while stopping leaves OFF free of any latched state
   task automatic stop_off();
      run_req      = 1'b0;
      vin_meas     = V_OK;
      clear_faults = 1'b1;
      @(negedge sys_clk);
      clear_faults = 1'b0;
      @(negedge sys_clk);
      `CHK(seq_state, 3'h0, "not off")
      `CHK(alert_output_line_n, 1'b1, "alert kept")
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      host.rd(`VUF_CMD_VIN_UV_ACTION, rdat);
      `CHK(rdat, {8'h00, `VUF_RST_ACTION}, "action reset")
      host.rd(`VUF_CMD_TURN_ON_DELAY_TIME, rdat);
      `CHK(rdat, `VUF_RST_TURN_ON_DELAY_TIME, "delay reset")
      host.rd(`VUF_CMD_VIN_UV_LIMIT, rdat);
      `CHK(rdat, 16'h0010, "limit strap")
      host.rd(`VUF_CMD_PG_ON, rdat);
      `CHK(rdat, 16'h0100, "pg strap")
      host.rd(8'h5B, rdat);
      `CHK(rdat, 16'h0000, "unmapped read")
      host.wr(`VUF_CMD_VIN_UV_ACTION, 16'hFFC7);
      host.rd(`VUF_CMD_VIN_UV_ACTION, rdat);
      `CHK(rdat, 16'h00C7, "action byte")
      // Same 16 V as the strap but only when exponent is read as signed
      host.wr(`VUF_CMD_VIN_UV_LIMIT, 16'hF820);
      host.rd(`VUF_CMD_VIN_UV_LIMIT, rdat);
      `CHK(rdat, 16'hF820, "limit write")
      host.wr(`VUF_CMD_PG_ON, 16'h0180);
   endtask

   task automatic t_ton(input logic [15:0] code, input int lo);
      int n;
      host.wr(`VUF_CMD_TURN_ON_DELAY_TIME, code);
      vin_meas = V_OK;
      run_req  = 1'b1;
      n = 0;
      while (ramp_active !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK((n >= lo) && (n <= lo + 4), 1'b1, "turn-on delay")
      n = 0;
      while (ramp_active === 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK((n >= MS) && (n <= MS + 3), 1'b1, "rise time")
      `CHK(seq_state, 3'h3, "on state")
      bias_ok = 1'b0;
      repeat (2) @(negedge sys_clk);
      `CHK(output_enabled, 1'b0, "bias loss")
      bias_ok = 1'b1;
      run_req = 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic t_pg();
      vin_meas  = V_OK;
      run_req   = 1'b1;
      vout_meas = 16'h0150;
      wait_st(3'h3, 200);
      repeat (2) @(negedge sys_clk);
      `CHK(power_good, 1'b0, "pg below on")
      vout_meas = 16'h0200;
      repeat (2) @(negedge sys_clk);
      `CHK(power_good, 1'b1, "pg above on")
      vout_meas = 16'h00C0;
      repeat (2) @(negedge sys_clk);
      `CHK(power_good, 1'b1, "pg hysteresis")
      vout_meas = 16'h0040;
      repeat (2) @(negedge sys_clk);
      `CHK(power_good, 1'b0, "pg below limit")
      stop_off();
   endtask

   task automatic t_latch();
      start_on(8'h80);
      `CHK(seq_state, 3'h5, "latched")
      `CHK(vin_uv_fault_flag, 1'b1, "flag")
      `CHK(alert_output_line_n, 1'b0, "alert")
      vin_meas = V_OK;
      repeat (50) @(negedge sys_clk);
      `CHK(output_enabled, 1'b0, "stays off")
      stop_off();
   endtask

   task automatic t_hold();
      start_on(8'hC7);
      `CHK(seq_state, 3'h6, "hold")
      vin_meas = V_OK;
      wait_st(3'h1, 3);
      `CHK(seq_state, 3'h1, "resume")
      `CHK(vin_uv_fault_flag, 1'b1, "flag kept")
      stop_off();
   endtask

   task automatic t_retry();
      int n;
      start_on(8'hB8);
      `CHK(seq_state, 3'h4, "retry")
      n = 0;
      while (seq_state !== 3'h1 && n < 800) begin
         @(negedge sys_clk);
         n++;
      end
      `CHK((n >= 70 * MS - 8) && (n <= 70 * MS + 4), 1'b1, "retry time")
      other_fault = 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK(seq_state, 3'h0, "other fault stop")
      other_fault = 1'b0;
      stop_off();
   endtask

   initial begin
      arst_n       = 1'b0;
      clk_en       = 1'b1;
      clear_faults = 1'b0;
      vin_meas     = V_OK;
      vout_meas    = 16'h0000;
      run_req      = 1'b0;
      bias_ok      = 1'b1;
      other_fault  = 1'b0;
      repeat (2) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      t_regs();
      t_ton(16'h0004, 4 * MS);
      t_ton(16'h0000, 3 * MS);
      t_pg();
      t_latch();
      t_hold();
      t_retry();
      results();
   end

   // Whole run is about 1100 cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         $display("ERROR %0t run too long", $time);
         results();
      end
   end
endmodule

bind vuf_seq vuf_seq_chk #(.MS_CYCLES(MS_CYCLES)) chk (.sys_clk, .arst_n, .clk_en,
   .clear_faults, .run_req, .bias_ok, .other_fault, .vout_meas, .vout_uv_limit,
   .alert_output_line_n, .vin_uv_fault_flag, .output_enabled, .ramp_active, .power_good,
   .seq_state);
